// ---- design/front_panel_params.svh ----
// timing, framing and field constants for the front panel controller
`ifndef FRONT_PANEL_PARAMS_SVH
`define FRONT_PANEL_PARAMS_SVH
`define FP_CLK_HZ       25000000
`define FP_BAUD         19200
`define FP_NUM_KEYS     17
`define FP_DATA_BITS    8
`define FP_LAST_BIT     3'h7
`define FP_SYNC_BYTE    8'ha5
`define FP_CMD_CODE     4'hc
`define FP_LED_RED_BIT  0
`define FP_LED_YEL_BIT  1
`define FP_RPT_BYTES    4
`define FP_RPT_LAST     2'h3
`define FP_WHEEL_MAX    6'h1f
`define FP_WHEEL_MIN    6'h21
`endif

// ---- design/fp_pkg.sv ----
// state types for the front panel controller
package fp_pkg;
  typedef enum logic [3:0] {
    SER_IDLE  = 4'b0001,
    SER_START = 4'b0010,
    SER_DATA  = 4'b0100,
    SER_STOP  = 4'b1000
  } ser_state_t;

  typedef enum logic [1:0] {
    RPT_IDLE = 2'b01,
    RPT_SEND = 2'b10
  } rpt_state_t;
endpackage

// ---- design/serial_char_link.sv ----
// two-wire asynchronous character transmitter and receiver, 8N1
`timescale 1ns/1ns
`include "front_panel_params.svh"
module serial_char_link #(
  parameter int CLK_HZ = `FP_CLK_HZ,
  parameter int BAUD   = `FP_BAUD
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            tx_line,
  input  wire logic       rx_line,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_frame_err
);
  import fp_pkg::*;

  localparam int BIT_CYC = (CLK_HZ + BAUD / 2) / BAUD;
  localparam int HALF    = BIT_CYC / 2;
  localparam int CW      = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] BIT_LOAD  = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF_LOAD = CW'(HALF - 1);

  ser_state_t    tx_st_r;
  logic [CW-1:0] tx_cnt_r;
  logic [2:0]    tx_idx_r;
  logic [7:0]    tx_sh_r;
  ser_state_t    rx_st_r;
  logic [CW-1:0] rx_cnt_r;
  logic [2:0]    rx_idx_r;
  logic [7:0]    rx_sh_r;
  logic          rx_q_r;

  assign tx_ready = (tx_st_r == SER_IDLE);

  // transmitter: start bit, eight data bits lsb first, one stop bit, no handshake lines
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tx_st_r  <= SER_IDLE;
      tx_cnt_r <= '0;
      tx_idx_r <= 3'h0;
      tx_sh_r  <= 8'h00;
      tx_line  <= 1'b1;
    end
    else if (clk_en)
    begin
      unique case (tx_st_r)
        SER_IDLE:
        begin
          tx_line <= 1'b1;
          if (tx_valid) // RULE_04
          begin
            tx_sh_r  <= tx_data;
            tx_line  <= 1'b0;
            tx_cnt_r <= BIT_LOAD; // RULE_05
            tx_st_r  <= SER_START;
          end
        end
        SER_START, SER_DATA:
        begin
          if (tx_cnt_r == '0)
          begin
            tx_cnt_r <= BIT_LOAD;
            if (tx_st_r == SER_DATA && tx_idx_r == `FP_LAST_BIT)
            begin
              tx_line <= 1'b1; // RULE_10
              tx_st_r <= SER_STOP;
            end
            else
            begin
              tx_line  <= tx_sh_r[0];
              tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
              tx_idx_r <= (tx_st_r == SER_START) ? 3'h0 : tx_idx_r + 3'h1;
              tx_st_r  <= SER_DATA;
            end
          end
          else
            tx_cnt_r <= tx_cnt_r - 1'b1;
        end
        SER_STOP:
        begin
          if (tx_cnt_r == '0)
            tx_st_r <= SER_IDLE;
          else
            tx_cnt_r <= tx_cnt_r - 1'b1;
        end
      endcase
    end
  end

  // receiver: samples mid-bit; a start bit that is gone at mid-bit is taken as a glitch
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_st_r      <= SER_IDLE;
      rx_cnt_r     <= '0;
      rx_idx_r     <= 3'h0;
      rx_sh_r      <= 8'h00;
      rx_q_r       <= 1'b1;
      rx_valid     <= 1'b0;
      rx_data      <= 8'h00;
      rx_frame_err <= 1'b0;
    end
    else if (clk_en)
    begin
      rx_q_r       <= rx_line;
      rx_valid     <= 1'b0;
      rx_frame_err <= 1'b0;
      unique case (rx_st_r)
        SER_IDLE:
        begin
          if (!rx_q_r)
          begin
            rx_cnt_r <= HALF_LOAD; // RULE_05
            rx_st_r  <= SER_START;
          end
        end
        SER_START:
        begin
          if (rx_cnt_r == '0)
          begin
            rx_cnt_r <= BIT_LOAD;
            rx_idx_r <= 3'h0;
            rx_st_r  <= rx_q_r ? SER_IDLE : SER_DATA;
          end
          else
            rx_cnt_r <= rx_cnt_r - 1'b1;
        end
        SER_DATA:
        begin
          if (rx_cnt_r == '0)
          begin
            rx_sh_r  <= {rx_q_r, rx_sh_r[7:1]};
            rx_cnt_r <= BIT_LOAD;
            rx_idx_r <= rx_idx_r + 3'h1;
            if (rx_idx_r == `FP_LAST_BIT)
              rx_st_r <= SER_STOP;
          end
          else
            rx_cnt_r <= rx_cnt_r - 1'b1;
        end
        SER_STOP:
        begin
          if (rx_cnt_r == '0)
          begin
            rx_valid     <= rx_q_r; // RULE_10
            rx_frame_err <= !rx_q_r;
            rx_data      <= rx_sh_r;
            rx_st_r      <= SER_IDLE;
          end
          else
            rx_cnt_r <= rx_cnt_r - 1'b1;
        end
      endcase
    end
  end

  // helper: enabled cycles spent in the start bit
  int start_len;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || tx_st_r != SER_START)
      start_len <= 0;
    else if (clk_en)
      start_len <= start_len + 1;
  end

  a_tx_idle_high: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
    tx_st_r == SER_IDLE |-> tx_line) else $error("line not high while idle");

  a_start_bit_len: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    tx_st_r == SER_START && clk_en && tx_cnt_r == '0 |-> start_len == BIT_CYC - 1)
    else $error("start bit length wrong");

  a_stop_bit_high: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_10
    tx_st_r == SER_STOP |-> tx_line) else $error("stop bit not high");
endmodule

// ---- design/front_panel_key_led_serial_ctrl.sv ----
// front panel command board: key and wheel reporting, alarm and standby leds
`timescale 1ns/1ns
`include "front_panel_params.svh"
// Overview of operation
// RULE_01: inputs for seventeen function keys, a rotary wheel and a power/standby switch.
// RULE_02: sample every key and the wheel, report their state to the host serially.
// RULE_03: wheel steps are forwarded to the host as menu navigation with key data.
// RULE_04: only a transmit and a receive line are used, no handshake signals.
// RULE_05: characters run at 19.2 kilobaud in both directions.
// RULE_06: alarm leds change only on commands received from the host.
// RULE_07: red led lit for active red alarm, yellow led for yellow alarm.
// RULE_08: standby led lit when switch selects standby and mains is connected.
// RULE_09: with two boards, system is on if either switch is on.
// RULE_10: characters are eight data bits, no parity, one stop bit.
module front_panel_key_led_serial_ctrl #(
  parameter int CLK_HZ = `FP_CLK_HZ,
  parameter int BAUD   = `FP_BAUD
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  input  wire logic [`FP_NUM_KEYS-1:0] key_in,
  input  wire logic                    wheel_a,
  input  wire logic                    wheel_b,
  input  wire logic                    power_standby_switch,
  input  wire logic                    mains_present,
  input  wire logic                    serial_rx,
  output logic                         serial_tx,
  output logic                         red_alarm_led,
  output logic                         yellow_alarm_led,
  output logic                         standby_indicator
);
  import fp_pkg::*;

  logic [`FP_NUM_KEYS-1:0] key_r;
  logic [`FP_NUM_KEYS-1:0] key_sent_r;
  logic                    sw_r;
  logic                    sw_sent_r;
  logic                    mains_r;
  logic                    wa_r;
  logic                    wb_r;
  logic                    wa_d_r;
  logic [5:0]              delta_r;
  logic [5:0]              delta_nxt;
  logic                    step;
  logic                    step_up;
  rpt_state_t              rpt_st_r;
  logic [1:0]              rpt_idx_r;
  logic [7:0]              rpt_buf_r [`FP_RPT_BYTES];
  logic                    tx_valid_r;
  logic [7:0]              tx_data_r;
  logic                    tx_ready;
  logic                    rx_valid;
  logic [7:0]              rx_data;
  logic                    rx_frame_err;
  logic                    report_due;
  logic                    led_cmd;

  // signed saturating add of one wheel step; a fast spin must not wrap the sign
  function automatic logic [5:0] sat_step(input logic [5:0] acc, input logic up);
    logic [5:0] r;
    r = acc;
    if (up && acc != `FP_WHEEL_MAX)
      r = acc + 6'h01;
    else if (!up && acc != `FP_WHEEL_MIN)
      r = acc - 6'h01;
    return r;
  endfunction

  // front panel inputs are synchronous; one register stage gives a stable snapshot
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      key_r   <= '0;
      sw_r    <= 1'b0;
      mains_r <= 1'b0;
      wa_r    <= 1'b0;
      wb_r    <= 1'b0;
      wa_d_r  <= 1'b0;
    end
    else if (clk_en)
    begin
      key_r   <= key_in; // RULE_01
      sw_r    <= power_standby_switch;
      mains_r <= mains_present;
      wa_r    <= wheel_a;
      wb_r    <= wheel_b;
      wa_d_r  <= wa_r;
    end
  end

  // wheel decode: one step per edge of phase a, direction from phase b
  assign step      = (wa_r != wa_d_r);
  assign step_up   = (wa_r != wb_r);
  assign delta_nxt = sat_step(report_due ? 6'h00 : delta_r, step_up);

  // a report goes out when anything changed since the last one
  assign report_due = (rpt_st_r == RPT_IDLE) &&
                      (key_r != key_sent_r || sw_r != sw_sent_r || delta_r != 6'h00);

  // step accumulator; a step in the snapshot cycle starts the next count, it is not lost
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      delta_r <= 6'h00;
    else if (clk_en)
    begin
      if (step)
        delta_r <= delta_nxt; // RULE_03
      else if (report_due)
        delta_r <= 6'h00;
    end
  end

  // report sequencer: sync, keys low, keys high, {key16, standby, wheel delta}
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rpt_st_r   <= RPT_IDLE;
      rpt_idx_r  <= 2'h0;
      key_sent_r <= '0;
      sw_sent_r  <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
      for (int i = 0; i < `FP_RPT_BYTES; i++)
        rpt_buf_r[i] <= 8'h00;
    end
    else if (clk_en)
    begin
      unique case (rpt_st_r)
        RPT_IDLE:
        begin
          if (report_due)
          begin
            rpt_buf_r[0] <= `FP_SYNC_BYTE; // RULE_02
            rpt_buf_r[1] <= key_r[7:0];
            rpt_buf_r[2] <= key_r[15:8];
            rpt_buf_r[3] <= {key_r[16], sw_r, delta_r}; // RULE_03
            key_sent_r   <= key_r;
            sw_sent_r    <= sw_r;
            rpt_idx_r    <= 2'h0;
            rpt_st_r     <= RPT_SEND;
          end
        end
        RPT_SEND:
        begin
          if (tx_valid_r && tx_ready)
          begin
            tx_valid_r <= 1'b0;
            rpt_idx_r  <= rpt_idx_r + 2'h1;
            if (rpt_idx_r == `FP_RPT_LAST)
              rpt_st_r <= RPT_IDLE;
          end
          else if (!tx_valid_r)
          begin
            tx_valid_r <= 1'b1;
            tx_data_r  <= rpt_buf_r[rpt_idx_r];
          end
        end
      endcase
    end
  end

  // host command: upper nibble is the led code, low bits the alarm states
  assign led_cmd = rx_valid && !rx_frame_err && rx_data[7:4] == `FP_CMD_CODE;

  // alarm leds move on host command only, never from local state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      red_alarm_led    <= 1'b0;
      yellow_alarm_led <= 1'b0;
    end
    else if (clk_en && led_cmd) // RULE_06
    begin
      red_alarm_led    <= rx_data[`FP_LED_RED_BIT]; // RULE_07
      yellow_alarm_led <= rx_data[`FP_LED_YEL_BIT]; // RULE_07
    end
  end

  // standby lamp needs mains; the two-board on decision belongs to the host
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      standby_indicator <= 1'b0;
    else if (clk_en)
      standby_indicator <= sw_r & mains_r; // RULE_08
  end

  serial_char_link #(
    .CLK_HZ (CLK_HZ),
    .BAUD   (BAUD)
  ) u_link (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .clk_en       (clk_en),
    .tx_valid     (tx_valid_r),
    .tx_data      (tx_data_r),
    .tx_ready     (tx_ready),
    .tx_line      (serial_tx),
    .rx_line      (serial_rx),
    .rx_valid     (rx_valid),
    .rx_data      (rx_data),
    .rx_frame_err (rx_frame_err)
  );

  sequence s_cmd_seen;
    clk_en && led_cmd;
  endsequence

  sequence s_no_cmd;
    clk_en && !led_cmd;
  endsequence

  a_led_hold_nocmd: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
    s_no_cmd |=> $stable(red_alarm_led) && $stable(yellow_alarm_led))
    else $error("alarm led changed without command");

  a_red_follows_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
    s_cmd_seen |=> red_alarm_led == $past(rx_data[`FP_LED_RED_BIT]))
    else $error("red led not set by command");

  a_yel_follows_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
    s_cmd_seen |=> yellow_alarm_led == $past(rx_data[`FP_LED_YEL_BIT]))
    else $error("yellow led not set by command");

  a_standby_lamp: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_08
    clk_en ##1 clk_en |=> standby_indicator == $past(sw_r & mains_r))
    else $error("standby led wrong");

  a_key_report: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    rpt_st_r == RPT_IDLE && clk_en && key_r != key_sent_r |=> rpt_st_r == RPT_SEND)
    else $error("key change not reported");

  a_sync_first: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    rpt_st_r == RPT_SEND && tx_valid_r && rpt_idx_r == 2'h0 |-> tx_data_r == `FP_SYNC_BYTE)
    else $error("report does not open with sync");

  a_wheel_in_report: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_03
    clk_en && report_due |=> rpt_buf_r[3][5:0] == $past(delta_r))
    else $error("wheel delta not captured");
endmodule

// ---- verif/host_model.sv ----
// host side model: sends led command characters and collects report characters
`timescale 1ns/1ns
module host_model #(
  parameter int   BIT_CYC      = 16,
  parameter logic PEER_STANDBY = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic serial_tx,
  output logic      serial_rx
);
  logic [7:0] rx_q[$];
  int         frame_errs;
  int         rx_count;
  logic       board_standby;
  logic       system_on;

  // line idles high, nothing else to hand-shake with
  initial
  begin
    serial_rx     = 1'b1;
    frame_errs    = 0;
    rx_count      = 0;
    board_standby = 1'b0;
  end

  // two boards: the system stays on while either switch is on; only one board
  // is modelled, so the peer's switch is a fixed parameter
  assign system_on = !(board_standby && PEER_STANDBY);

  // one character, lsb first; caller enters just after a rising edge
  // a broken stop bit is released for one bit time so the line idles again
  task automatic send_byte(input logic [7:0] b, input logic stop_ok, input int gap);
    logic [9:0] fr;
    fr = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      serial_rx <= fr[i];
      repeat (BIT_CYC) @(posedge clk_sys);
    end
    if (!stop_ok)
    begin
      serial_rx <= 1'b1;
      repeat (BIT_CYC) @(posedge clk_sys);
    end
    repeat (gap) @(posedge clk_sys);
  endtask

  // receiver: mid-bit sampling from the start edge, stop bit must be high
  always
  begin : rx_proc
    logic [7:0] d;
    @(negedge serial_tx);
    repeat (BIT_CYC / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk_sys);
      d[i] = serial_tx;
    end
    repeat (BIT_CYC) @(posedge clk_sys);
    if (serial_tx !== 1'b1)
      frame_errs++;
    // reports align by byte position; the fourth byte carries the switch
    if (rx_count % 4 == 3)
      board_standby = d[6];
    rx_count++;
    rx_q.push_back(d);
  end
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the front panel key, wheel and led controller
`timescale 1ns/1ns
`include "front_panel_params.svh"
`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb;
  // short bit time keeps the run small: 16 cycles a bit
  localparam int CLK_HZ  = 25000000;
  localparam int BAUD    = 1562500;
  localparam int BIT_CYC = CLK_HZ / BAUD;

  logic                    clk_sys = 1'b0;
  logic                    rst_n;
  logic                    clk_en;
  logic [`FP_NUM_KEYS-1:0] key_in;
  logic                    wheel_a;
  logic                    wheel_b;
  logic                    power_standby_switch;
  logic                    mains_present;
  logic                    serial_rx;
  logic                    serial_tx;
  logic                    red_alarm_led;
  logic                    yellow_alarm_led;
  logic                    standby_indicator;
  int                      bad_count = 0;
  int                      checks_done = 0;

  always #20 clk_sys = ~clk_sys;

  front_panel_key_led_serial_ctrl #(.CLK_HZ(CLK_HZ), .BAUD(BAUD))
    front_panel_key_led_serial_ctrl_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .key_in(key_in),
    .wheel_a(wheel_a), .wheel_b(wheel_b), .power_standby_switch(power_standby_switch),
    .mains_present(mains_present), .serial_rx(serial_rx), .serial_tx(serial_tx),
    .red_alarm_led(red_alarm_led), .yellow_alarm_led(yellow_alarm_led),
    .standby_indicator(standby_indicator));

  host_model #(.BIT_CYC(BIT_CYC)) host_model_i (
    .clk_sys(clk_sys), .serial_tx(serial_tx), .serial_rx(serial_rx));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // wait, bounded, for one whole four-character report
  task automatic get_report(output logic [31:0] r);
    int n;
    n = 0;
    r = 32'hxxxxxxxx;
    while (host_model_i.rx_q.size() < 4 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    if (host_model_i.rx_q.size() < 4)
      `CHK("report arrival", 1'b1, 1'b0)
    else
      for (int i = 0; i < 4; i++)
        r = {r[23:0], host_model_i.rx_q.pop_front()};
  endtask

  task automatic check_report(input string nm, input logic [31:0] exp);
    logic [31:0] r;
    get_report(r);
    `CHK(nm, exp, r)
  endtask

  // commands back to back, leds judged as each stop bit ends
  task automatic test_leds();
    logic [1:0] v[4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    foreach (v[i])
    begin
      host_model_i.send_byte({`FP_CMD_CODE, 2'h0, v[i]}, 1'b1, 0);
      `CHK("red led", v[i][0], red_alarm_led)
      `CHK("yellow led", v[i][1], yellow_alarm_led)
    end
  endtask

  // foreign code and broken frame leave the leds alone
  task automatic test_refused();
    host_model_i.send_byte(8'h53, 1'b1, 4);
    `CHK("foreign code", 2'h0, {yellow_alarm_led, red_alarm_led})
    host_model_i.send_byte(8'hc3, 1'b0, 4);
    `CHK("bad stop bit", 2'h0, {yellow_alarm_led, red_alarm_led})
    host_model_i.send_byte(8'hc3, 1'b1, 4);
    `CHK("after refusal", 2'h3, {yellow_alarm_led, red_alarm_led})
    `CHK("no report from leds", 0, host_model_i.rx_q.size())
  endtask

  task automatic test_keys();
    key_in <= 17'h13c5a;
    check_report("key report", {`FP_SYNC_BYTE, 8'h5a, 8'h3c, 8'h80});
    key_in <= 17'h00000;
    check_report("key release", {`FP_SYNC_BYTE, 24'h000000});
  endtask

  // sums wheel deltas over however many reports the steps were split into
  task automatic wheel_steps(input logic [1:0] s[3], input logic signed [7:0] exp);
    logic signed [7:0] sum;
    logic [31:0]       r;
    sum = 8'sd0;
    foreach (s[i])
    begin
      {wheel_a, wheel_b} <= s[i];
      cyc(4);
    end
    cyc(2500);
    `CHK("wheel report count", 0, host_model_i.rx_q.size() % 4)
    while (host_model_i.rx_q.size() >= 4)
    begin
      get_report(r);
      `CHK("wheel sync and keys", {`FP_SYNC_BYTE, 16'h0000}, r[31:8])
      sum = sum + 8'($signed(r[5:0]));
    end
    `CHK("wheel delta", exp, sum)
  endtask

  task automatic test_wheel();
    wheel_steps('{2'b10, 2'b11, 2'b01}, 8'sd2);
    wheel_steps('{2'b00, 2'b11, 2'b10}, -8'sd1);
  endtask

  // standby needs switch and mains; a frozen clock enable holds the led
  task automatic test_standby();
    power_standby_switch <= 1'b1;
    mains_present        <= 1'b1;
    cyc(3);
    `CHK("standby on", 1'b1, standby_indicator)
    check_report("switch report", {`FP_SYNC_BYTE, 24'h000040});
    `CHK("both in standby", 1'b0, host_model_i.system_on)
    mains_present <= 1'b0;
    cyc(3);
    `CHK("no mains", 1'b0, standby_indicator)
    clk_en        <= 1'b0;
    mains_present <= 1'b1;
    cyc(6);
    `CHK("frozen", 1'b0, standby_indicator)
    clk_en <= 1'b1;
    cyc(3);
    `CHK("thawed", 1'b1, standby_indicator)
    power_standby_switch <= 1'b0;
    cyc(3);
    `CHK("switched on", 1'b0, standby_indicator)
    check_report("switch back", {`FP_SYNC_BYTE, 24'h000000});
    `CHK("system on", 1'b1, host_model_i.system_on)
  endtask

  initial
  begin
    rst_n                = 1'b0;
    clk_en               = 1'b1;
    key_in               = '0;
    wheel_a              = 1'b0;
    wheel_b              = 1'b0;
    power_standby_switch = 1'b0;
    mains_present        = 1'b0;
    cyc(12);
    rst_n <= 1'b1;
    cyc(2);
    `CHK("idle line", 1'b1, serial_tx)
    `CHK("leds after reset", 3'h0, {red_alarm_led, yellow_alarm_led, standby_indicator})
    test_leds();
    test_refused();
    test_keys();
    test_wheel();
    test_standby();
    `CHK("report stop bits", 0, host_model_i.frame_errs)
    report_and_stop();
  end

  // hang guard: the sequence needs well under 15000 cycles
  initial
  begin
    cyc(40000);
    bad_count++;
    $display("ERROR watchdog expected done seen hang");
    report_and_stop();
  end
endmodule
